/* src/spm_pin_mux.v */
/*
 Pin multiplexer for two serial groups and six upper address pins, with
 pulldown inhibit, clock output source and clock-off control over APB.
 Assumes all inputs synchronous to clk_sys; pads resolve out/oe_b pairs.
*/
`timescale 1ns/1ps
`include "spm_regs.vh"

module spm_pin_mux #(
	parameter SRC_CNT = 16
) (
	input wire clk_sys,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [SRC_CNT-1:0] gen_clocks,
	input wire card0_clock,
	input wire card0_cmd_out,
	input wire card0_cmd_oe_b,
	input wire [3:0] card0_dat_out,
	input wire [3:0] card0_dat_oe_b,
	input wire card1_clock,
	input wire card1_cmd_out,
	input wire card1_cmd_oe_b,
	input wire [3:0] card1_dat_out,
	input wire [3:0] card1_dat_oe_b,
	input wire audio0_bit_clock,
	input wire audio0_clk_oe_b,
	input wire audio0_fs_out,
	input wire audio0_fs_oe_b,
	input wire audio0_tx,
	input wire audio1_bit_clock,
	input wire audio1_clk_oe_b,
	input wire audio1_fs_out,
	input wire audio1_fs_oe_b,
	input wire audio1_tx,
	input wire [5:0] gpio_group0_out,
	input wire [5:0] gpio_group0_oe_b,
	input wire [5:0] gpio_group1_out,
	input wire [5:0] gpio_group1_oe_b,
	input wire [5:0] ext_mem_upper_address,
	input wire [5:0] gpio_address_out,
	input wire [5:0] gpio_address_oe_b,
	input wire [5:0] group0_pin_in,
	input wire [5:0] group1_pin_in,
	input wire [5:0] addr_pin_in,
	output reg [5:0] group0_pin_out,
	output reg [5:0] group0_pin_oe_b,
	output reg [5:0] group1_pin_out,
	output reg [5:0] group1_pin_oe_b,
	output reg [5:0] addr_pin_out,
	output reg [5:0] addr_pin_oe_b,
	output reg [5:0] gpio_group0_in,
	output reg [5:0] gpio_group1_in,
	output reg [5:0] gpio_address_in,
	output reg [11:0] serial_pulldown_inhibit,
	output reg [15:0] pulldown_inhibit_2,
	output reg [15:0] pulldown_inhibit_3,
	output reg debug_clock_output
);

	// -----------------------------------------------------------
	// Reset synchroniser
	// -----------------------------------------------------------
	reg rst_meta_b;
	reg rst_sync_b;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// -----------------------------------------------------------
	// Registers
	// -----------------------------------------------------------
	reg [31:0] external_bus_select_reg;
	reg [15:0] pulldown_inhibit_1;
	reg [`SPM_CLK_SRC_W-1:0] clock_output_source_select;
	reg clock_output_off_bit;

	wire [1:0] serial_group0_mode;
	wire [1:0] serial_group1_mode;
	wire [5:0] addr_mode;

	// All pin mux controls live in the one select register
	assign serial_group0_mode = external_bus_select_reg[`SPM_EBS_G0_LSB+1:`SPM_EBS_G0_LSB];
	assign serial_group1_mode = external_bus_select_reg[`SPM_EBS_G1_LSB+1:`SPM_EBS_G1_LSB];
	assign addr_mode = external_bus_select_reg[`SPM_EBS_ADDR_LSB+5:`SPM_EBS_ADDR_LSB];

	function addr_hit;
		input [31:0] a;
		input [`SPM_ADDR_W-1:0] target;
		begin
			addr_hit = (a[31:`SPM_ADDR_W] == 14'h0000) && (a[`SPM_ADDR_W-1:0] == target);
		end
	endfunction

	wire hit_ebs;
	wire hit_p1;
	wire hit_p2;
	wire hit_p3;
	wire hit_src;
	wire hit_stat;
	wire hit_any;
	wire access;
	wire write_fire;

	assign hit_ebs = addr_hit(paddr, `SPM_ADDR_EXT_BUS_SEL);
	assign hit_p1 = addr_hit(paddr, `SPM_ADDR_PULL_INH1);
	assign hit_p2 = addr_hit(paddr, `SPM_ADDR_PULL_INH2);
	assign hit_p3 = addr_hit(paddr, `SPM_ADDR_PULL_INH3);
	assign hit_src = addr_hit(paddr, `SPM_ADDR_CLK_SRC);
	assign hit_stat = addr_hit(paddr, `SPM_ADDR_CPU_STAT3);
	assign hit_any = hit_ebs | hit_p1 | hit_p2 | hit_p3 | hit_src | hit_stat;
	assign access = psel & penable & ~pready;
	// Write lands only at the edge that completes the transfer
	assign write_fire = psel & penable & pready & pwrite;

	// -----------------------------------------------------------
	// APB slave: one wait state, answer in second access cycle
	// -----------------------------------------------------------
	reg [31:0] next_prdata;

	always @* begin
		next_prdata = 32'h00000000;
		if (hit_ebs)
			next_prdata = external_bus_select_reg;
		else if (hit_p1)
			next_prdata = {16'h0000, pulldown_inhibit_1};
		else if (hit_p2)
			next_prdata = {16'h0000, pulldown_inhibit_2};
		else if (hit_p3)
			next_prdata = {16'h0000, pulldown_inhibit_3};
		else if (hit_src)
			next_prdata = {{(32-`SPM_CLK_SRC_W){1'b0}}, clock_output_source_select};
		else if (hit_stat)
			next_prdata = {31'h00000000, clock_output_off_bit};
	end

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			external_bus_select_reg <= `SPM_EBS_RESET;
			pulldown_inhibit_1 <= `SPM_PULL_RESET;
			pulldown_inhibit_2 <= `SPM_PULL_RESET;
			pulldown_inhibit_3 <= `SPM_PULL_RESET;
			clock_output_source_select <= `SPM_CLK_SRC_RESET;
			clock_output_off_bit <= `SPM_CLK_OFF_RESET;
		end else begin
			pready <= access;
			pslverr <= access & ~hit_any;
			prdata <= (access & ~pwrite) ? next_prdata : 32'h00000000;
			if (write_fire) begin
				// Serial mode fields reset to card functions, address pins to ext_mem_upper_address
				if (hit_ebs)
					external_bus_select_reg <= pwdata & `SPM_EBS_MASK;
				if (hit_p1)
					pulldown_inhibit_1 <= pwdata[15:0];
				if (hit_p2)
					pulldown_inhibit_2 <= pwdata[15:0];
				if (hit_p3)
					pulldown_inhibit_3 <= pwdata[15:0];
				if (hit_src)
					clock_output_source_select <= pwdata[`SPM_CLK_SRC_W-1:0];
				// Clock-off set by boot code, cleared by software
				if (hit_stat)
					clock_output_off_bit <= pwdata[`SPM_CLK_OFF_BIT];
			end
		end
	end

	// -----------------------------------------------------------
	// Serial groups
	// -----------------------------------------------------------
	wire [5:0] g0_out;
	wire [5:0] g0_oe_b;
	wire [5:0] g1_out;
	wire [5:0] g1_oe_b;

	// Group zero functions
	spm_group_mux u_group0 (
		.mode(serial_group0_mode),
		.card_clk(card0_clock),
		.card_cmd_out(card0_cmd_out),
		.card_cmd_oe_b(card0_cmd_oe_b),
		.card_dat_out(card0_dat_out),
		.card_dat_oe_b(card0_dat_oe_b),
		.audio_clk_out(audio0_bit_clock),
		.audio_clk_oe_b(audio0_clk_oe_b),
		.audio_fs_out(audio0_fs_out),
		.audio_fs_oe_b(audio0_fs_oe_b),
		.audio_tx(audio0_tx),
		.gpio_out(gpio_group0_out),
		.gpio_oe_b(gpio_group0_oe_b),
		.pin_out(g0_out),
		.pin_oe_b(g0_oe_b)
	);

	// Group one functions
	spm_group_mux u_group1 (
		.mode(serial_group1_mode),
		.card_clk(card1_clock),
		.card_cmd_out(card1_cmd_out),
		.card_cmd_oe_b(card1_cmd_oe_b),
		.card_dat_out(card1_dat_out),
		.card_dat_oe_b(card1_dat_oe_b),
		.audio_clk_out(audio1_bit_clock),
		.audio_clk_oe_b(audio1_clk_oe_b),
		.audio_fs_out(audio1_fs_out),
		.audio_fs_oe_b(audio1_fs_oe_b),
		.audio_tx(audio1_tx),
		.gpio_out(gpio_group1_out),
		.gpio_oe_b(gpio_group1_oe_b),
		.pin_out(g1_out),
		.pin_oe_b(g1_oe_b)
	);

	// Gpio input masks per mode
	function [5:0] gpio_in_mask;
		input [1:0] mode;
		begin
			case (mode)
			`SPM_MODE_AUDIO: gpio_in_mask = 6'h30;
			`SPM_MODE_GPIO: gpio_in_mask = 6'h3f;
			default: gpio_in_mask = 6'h00;
			endcase
		end
	endfunction

	// -----------------------------------------------------------
	// Registered pin outputs
	// -----------------------------------------------------------
	integer i;

	always @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			group0_pin_out <= 6'h00;
			group0_pin_oe_b <= 6'h3f;
			group1_pin_out <= 6'h00;
			group1_pin_oe_b <= 6'h3f;
			addr_pin_out <= 6'h00;
			addr_pin_oe_b <= 6'h3f;
			gpio_group0_in <= 6'h00;
			gpio_group1_in <= 6'h00;
			gpio_address_in <= 6'h00;
			serial_pulldown_inhibit <= 12'h000;
			debug_clock_output <= 1'b0;
		end else begin
			group0_pin_out <= g0_out;
			group0_pin_oe_b <= g0_oe_b;
			group1_pin_out <= g1_out;
			group1_pin_oe_b <= g1_oe_b;
			gpio_group0_in <= group0_pin_in & gpio_in_mask(serial_group0_mode);
			gpio_group1_in <= group1_pin_in & gpio_in_mask(serial_group1_mode);
			for (i = 0; i < 6; i = i + 1) begin
				// Per-pin address or gpio
				if (addr_mode[i]) begin
					addr_pin_out[i] <= gpio_address_out[i];
					addr_pin_oe_b[i] <= gpio_address_oe_b[i];
					gpio_address_in[i] <= addr_pin_in[i];
				end else begin
					addr_pin_out[i] <= ext_mem_upper_address[i];
					addr_pin_oe_b[i] <= 1'b0;
					gpio_address_in[i] <= 1'b0;
				end
			end
			// Pulldown control ignores function
			serial_pulldown_inhibit <= pulldown_inhibit_1[11:0];
			// Source select, gated by clock-off
			debug_clock_output <= ~clock_output_off_bit &
				gen_clocks[clock_output_source_select];
		end
	end

endmodule

/* src/spm_regs.vh */
/*
 Register offsets, field positions and reset values of the serial port and
 address pin multiplexer. Assumes inclusion by the modules under src/.
*/
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// ---------------------------------------------------------------
// Register indices and byte addresses
// ---------------------------------------------------------------
`define SPM_IDX_PULL_INH1 16'h1c17
`define SPM_IDX_PULL_INH2 16'h1c18
`define SPM_IDX_PULL_INH3 16'h1c19
`define SPM_IDX_EXT_BUS_SEL 16'h1c00
`define SPM_IDX_CLK_SRC 16'h1c24
`define SPM_IDX_CPU_STAT3 16'h1c25
`define SPM_ADDR_PULL_INH1 18'h0705c
`define SPM_ADDR_PULL_INH2 18'h07060
`define SPM_ADDR_PULL_INH3 18'h07064
`define SPM_ADDR_EXT_BUS_SEL 18'h07000
`define SPM_ADDR_CLK_SRC 18'h07090
`define SPM_ADDR_CPU_STAT3 18'h07094
`define SPM_ADDR_W 18

// ---------------------------------------------------------------
// External bus select fields
// ---------------------------------------------------------------
`define SPM_EBS_ADDR_LSB 0
`define SPM_EBS_G0_LSB 8
`define SPM_EBS_G1_LSB 10
`define SPM_EBS_MASK 32'h00000f3f
`define SPM_EBS_RESET 32'h00000000

// ---------------------------------------------------------------
// Serial group modes
// ---------------------------------------------------------------
`define SPM_MODE_CARD 2'h0
`define SPM_MODE_AUDIO 2'h1
`define SPM_MODE_GPIO 2'h2
`define SPM_MODE_RSVD 2'h3

// ---------------------------------------------------------------
// Other fields and resets
// ---------------------------------------------------------------
`define SPM_PULL_RESET 16'h0000
`define SPM_CLK_SRC_W 4
`define SPM_CLK_SRC_RESET 4'h0
`define SPM_CLK_OFF_BIT 0
`define SPM_CLK_OFF_RESET 1'b0

`endif

/* src/spm_group_mux.v */
/*
 One six-pin serial group: card, audio or gpio function per mode.
 Assumes the caller registers the results and gives synchronous inputs.
*/
`timescale 1ns/1ps
`include "spm_regs.vh"

module spm_group_mux (
	input wire [1:0] mode,
	input wire card_clk,
	input wire card_cmd_out,
	input wire card_cmd_oe_b,
	input wire [3:0] card_dat_out,
	input wire [3:0] card_dat_oe_b,
	input wire audio_clk_out,
	input wire audio_clk_oe_b,
	input wire audio_fs_out,
	input wire audio_fs_oe_b,
	input wire audio_tx,
	input wire [5:0] gpio_out,
	input wire [5:0] gpio_oe_b,
	output reg [5:0] pin_out,
	output reg [5:0] pin_oe_b
);

	// -----------------------------------------------------------
	// Function select
	// -----------------------------------------------------------
	always @* begin
		case (mode)
		`SPM_MODE_CARD: begin
			pin_out = {card_dat_out, card_cmd_out, card_clk};
			pin_oe_b = {card_dat_oe_b, card_cmd_oe_b, 1'b0};
		end
		`SPM_MODE_AUDIO: begin
			// Receive pin stays input
			pin_out = {gpio_out[5:4], 1'b0, audio_tx, audio_fs_out, audio_clk_out};
			pin_oe_b = {gpio_oe_b[5:4], 1'b1, 1'b0, audio_fs_oe_b, audio_clk_oe_b};
		end
		`SPM_MODE_GPIO: begin
			pin_out = gpio_out;
			pin_oe_b = gpio_oe_b;
		end
		default: begin
			// Reserved: all pins released
			pin_out = 6'h00;
			pin_oe_b = 6'h3f;
		end
		endcase
	end

endmodule

/* verification/spm_pin_mux_monitor.sv */
/*
 Checker for spm_pin_mux: pin routing, pulls, clock output, APB answer.
 Assumes a bind to spm_pin_mux and the single clock domain clk_sys.
*/
`timescale 1ns/1ps
`include "spm_regs.vh"
module spm_pin_mux_monitor #(
	parameter SRC_CNT = 16
) (
	input wire clk_sys,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [SRC_CNT-1:0] gen_clocks,
	input wire card1_clock,
	input wire card1_cmd_out,
	input wire [3:0] card1_dat_out,
	input wire audio1_bit_clock,
	input wire audio1_fs_out,
	input wire audio1_tx,
	input wire [5:0] gpio_group1_out,
	input wire [5:0] ext_mem_upper_address,
	input wire [5:0] gpio_address_out,
	input wire [5:0] group0_pin_oe_b,
	input wire [5:0] group1_pin_out,
	input wire [5:0] group1_pin_oe_b,
	input wire [5:0] addr_pin_out,
	input wire [11:0] serial_pulldown_inhibit,
	input wire debug_clock_output
);
// ----
// Shadow of written controls
// ----
reg [11:0] ebs;
reg [11:0] pl;
reg [3:0] src;
reg off;
reg [1:0] cnt;
wire [17:0] a = paddr[17:0];
wire [1:0] m1 = ebs[11:10];
wire wr = psel && penable && pready && pwrite;
wire hit = paddr[31:18] == 14'h0 && (a == `SPM_ADDR_PULL_INH1 || a == `SPM_ADDR_PULL_INH2
	|| a == `SPM_ADDR_PULL_INH3 || a == `SPM_ADDR_EXT_BUS_SEL || a == `SPM_ADDR_CLK_SRC
	|| a == `SPM_ADDR_CPU_STAT3);
always @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		ebs <= 12'h000;
		pl <= 12'h000;
		src <= 4'h0;
		off <= 1'h0;
		cnt <= 2'h0;
	end else begin
		cnt <= (cnt == 2'h3) ? cnt : cnt + 2'h1;
		if (wr && a == `SPM_ADDR_EXT_BUS_SEL)
			ebs <= pwdata[11:0];
		if (wr && a == `SPM_ADDR_PULL_INH1)
			pl <= pwdata[11:0];
		if (wr && a == `SPM_ADDR_CLK_SRC)
			src <= pwdata[3:0];
		if (wr && a == `SPM_ADDR_CPU_STAT3)
			off <= pwdata[0];
	end
end
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_b);
property p_grp1;
	cnt == 2'h3 && $past(m1) != 2'h1 |-> group1_pin_out == ($past(m1) == 2'h0 ?
		$past({card1_dat_out, card1_cmd_out, card1_clock}) : $past(m1) == 2'h2 ?
		$past(gpio_group1_out) : 6'h00);
endproperty
a_grp1: assert property (p_grp1) else $error("group one pins differ from mode");
property p_aud1;
	cnt == 2'h3 && $past(m1) == 2'h1 |-> group1_pin_oe_b[3] && group1_pin_out[5:4] ==
		$past(gpio_group1_out[5:4]) && group1_pin_out[2:0] ==
		$past({audio1_tx, audio1_fs_out, audio1_bit_clock});
endproperty
a_aud1: assert property (p_aud1) else $error("group one audio pins wrong");
property p_rsvd0;
	cnt == 2'h3 && $past(ebs[9:8]) == 2'h3 |-> group0_pin_oe_b == 6'h3f;
endproperty
a_rsvd0: assert property (p_rsvd0) else $error("reserved mode drives a pin");
property p_addr;
	cnt == 2'h3 |-> addr_pin_out == ($past(ebs[5:0]) & $past(gpio_address_out)
		| ~$past(ebs[5:0]) & $past(ext_mem_upper_address));
endproperty
a_addr: assert property (p_addr) else $error("address pin routing wrong");
property p_pull;
	$stable(pl) |-> serial_pulldown_inhibit == pl;
endproperty
a_pull: assert property (p_pull) else $error("pulldown inhibit differs");
property p_clk;
	cnt == 2'h3 && $stable(src) && $stable(off) |->
		debug_clock_output == ($past(gen_clocks[src]) && !off);
endproperty
a_clk: assert property (p_clk) else $error("clock output source wrong");
property p_rdy;
	psel && penable && !pready |=> pready ##1 !pready;
endproperty
a_rdy: assert property (p_rdy) else $error("ready not a single pulse");
property p_err;
	pready |-> pslverr == !hit;
endproperty
a_err: assert property (p_err) else $error("error flag wrong for address");
endmodule
bind spm_pin_mux spm_pin_mux_monitor #(.SRC_CNT(SRC_CNT)) mon_u (.*);

/* verification/tb_top.sv */
/*
 Bench for spm_pin_mux: resets, modes, pulls, clock output, bad address.
 Assumes the monitor is bound by its own file.
*/
`timescale 1ns/1ps
`include "spm_regs.vh"
module tb_top;
logic clk_sys = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
logic pready, pslverr, debug_clock_output, er;
logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
logic [15:0] gen_clocks = 16'h8421, pulldown_inhibit_2, pulldown_inhibit_3;
logic [11:0] serial_pulldown_inhibit;
logic card0_clock = 1'h0, card0_cmd_out = 1'h1, card0_cmd_oe_b = 1'h0;
logic card1_clock = 1'h1, card1_cmd_out = 1'h0, card1_cmd_oe_b = 1'h0;
logic [3:0] card0_dat_out = 4'h5, card1_dat_out = 4'ha, card0_dat_oe_b = 4'h0;
logic [3:0] card1_dat_oe_b = 4'h0;
logic audio0_bit_clock = 1'h0, audio0_fs_out = 1'h1, audio0_tx = 1'h1;
logic audio1_bit_clock = 1'h1, audio1_fs_out = 1'h1, audio1_tx = 1'h0;
logic audio0_clk_oe_b = 1'h0, audio0_fs_oe_b = 1'h0, audio1_clk_oe_b = 1'h0;
logic audio1_fs_oe_b = 1'h0;
logic [5:0] gpio_group0_out = 6'h2a, gpio_group0_oe_b = 6'h21;
logic [5:0] gpio_group1_out = 6'h35, gpio_group1_oe_b = 6'h0c;
logic [5:0] ext_mem_upper_address = 6'h0f, gpio_address_out = 6'h33;
logic [5:0] gpio_address_oe_b = 6'h2d, group0_pin_in = 6'h2d, group1_pin_in = 6'h1b;
logic [5:0] addr_pin_in = 6'h36, group0_pin_out, group0_pin_oe_b, group1_pin_out;
logic [5:0] group1_pin_oe_b, addr_pin_out, addr_pin_oe_b;
logic [5:0] gpio_group0_in, gpio_group1_in, gpio_address_in;
// Expected pins per mode: card, audio (receive masked), gpio, reserved
logic [5:0] e0 [4] = '{6'h16, 6'h26, 6'h2a, 6'h00};
logic [5:0] e1 [4] = '{6'h29, 6'h33, 6'h35, 6'h00};
logic [5:0] o0 [4] = '{6'h00, 6'h28, 6'h21, 6'h3f};
logic [5:0] o1 [4] = '{6'h00, 6'h08, 6'h0c, 6'h3f};
logic [5:0] am [4] = '{6'h00, 6'h2a, 6'h15, 6'h3f};
// Pins that hand their level back to gpio, per mode
logic [5:0] gm [4] = '{6'h00, 6'h30, 6'h3f, 6'h00};
logic [31:0] pd [3] = '{32'hfffff5a3, 32'h12345a5c, 32'h0000c3e1};
logic [17:0] ra [6] = '{`SPM_ADDR_PULL_INH1, `SPM_ADDR_PULL_INH2, `SPM_ADDR_PULL_INH3,
	`SPM_ADDR_EXT_BUS_SEL, `SPM_ADDR_CLK_SRC, `SPM_ADDR_CPU_STAT3};
int failures = 0, comparisons = 0;
spm_pin_mux dut_u (.*);
always #12.5 clk_sys = ~clk_sys;
task chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
endtask
task settle;
	begin
		repeat (2) @(posedge clk_sys);
		#1;
	end
endtask
// ----
// APB master: hold request until pready is sampled high
// ----
task apb(input logic w, input logic [17:0] ad, input logic [31:0] d);
	int n;
	begin
		n = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {14'h0, ad};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1) begin
			@(posedge clk_sys);
			n++;
		end
		chk(n, 1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	end
endtask
task t_reset;
	int i;
	begin
		for (i = 0; i < 6; i++) begin
			apb(1'h0, ra[i], 32'h0);
			chk(rd, 32'h0);
		end
		chk(group0_pin_out, e0[0]);
		chk(group1_pin_out, e1[0]);
		$display("reset test done");
	end
endtask
task t_groups;
	int m;
	logic [31:0] v;
	begin
		for (m = 0; m < 4; m++) begin
			v = {20'hfffff, 2'(3 - m), 2'(m), 2'h3, am[m]};
			apb(1'h1, `SPM_ADDR_EXT_BUS_SEL, v);
			apb(1'h0, `SPM_ADDR_EXT_BUS_SEL, 32'h0);
			chk(rd, v & `SPM_EBS_MASK);
			settle;
			chk(group0_pin_out & (m == 1 ? 6'h37 : 6'h3f), e0[m]);
			chk(group1_pin_out & (m == 2 ? 6'h37 : 6'h3f), e1[3 - m]);
			chk(group0_pin_oe_b, o0[m]);
			chk(group1_pin_oe_b, o1[3 - m]);
			chk(addr_pin_out, am[m] & 6'h33 | ~am[m] & 6'h0f);
			chk(addr_pin_oe_b, am[m] & gpio_address_oe_b);
			chk(gpio_address_in, am[m] & addr_pin_in);
			chk(gpio_group0_in, group0_pin_in & gm[m]);
			chk(gpio_group1_in, group1_pin_in & gm[3 - m]);
		end
		$display("mode test done");
	end
endtask
task t_pull;
	int i;
	begin
		for (i = 0; i < 3; i++) begin
			apb(1'h1, ra[i], pd[i]);
			apb(1'h0, ra[i], 32'h0);
			chk(rd, pd[i] & 32'h0000ffff);
		end
		settle;
		chk(serial_pulldown_inhibit, 12'h5a3);
		chk(pulldown_inhibit_2, 16'h5a5c);
		chk(pulldown_inhibit_3, 16'hc3e1);
		$display("pull test done");
	end
endtask
task t_clk;
	int s;
	begin
		for (s = 0; s < 16; s++) begin
			apb(1'h1, `SPM_ADDR_CLK_SRC, 32'(s));
			settle;
			chk(debug_clock_output, gen_clocks[s]);
		end
		apb(1'h1, `SPM_ADDR_CPU_STAT3, 32'h1);
		settle;
		chk(debug_clock_output, 1'h0);
		apb(1'h1, `SPM_ADDR_CPU_STAT3, 32'h0);
		settle;
		chk(debug_clock_output, 1'h1);
		$display("clock output test done");
	end
endtask
task t_bad;
	begin
		apb(1'h1, 18'h07004, 32'hffffffff);
		chk(er, 1'h1);
		apb(1'h0, 18'h07004, 32'h0);
		chk(rd, 32'h0);
		chk(er, 1'h1);
		apb(1'h0, `SPM_ADDR_EXT_BUS_SEL, 32'h0);
		chk(rd, 32'h0000033f);
		$display("unmapped test done");
	end
endtask
task t_midreset;
	begin
		apb(1'h1, `SPM_ADDR_EXT_BUS_SEL, 32'h00000a3f);
		@(posedge clk_sys);
		rst_b <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk(group0_pin_out, e0[0]);
		chk(group1_pin_out, e1[0]);
		chk(addr_pin_out, 6'h0f);
		apb(1'h0, `SPM_ADDR_EXT_BUS_SEL, 32'h0);
		chk(rd, 32'h0);
		$display("mid-run reset test done");
	end
endtask
task final_report;
	begin
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
initial begin
	repeat (2) @(posedge clk_sys);
	rst_b <= 1'h1;
	repeat (3) @(posedge clk_sys);
	t_reset;
	t_groups;
	t_pull;
	t_clk;
	t_bad;
	t_midreset;
	final_report;
end
initial begin
	#125000;
	failures++;
	$display("mismatch at %0t: watchdog expired", $time);
	final_report;
end
endmodule
